// *** rfk_link_if.sv ***
/*
 * Link between controller end and transmitter end: keying line and the
 * reference clock returned by the transmitter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface rfk_link_if;
    logic rf_data_keying_line;
    logic reference_clock_output;
    modport tx  (input rf_data_keying_line, output reference_clock_output);
    modport mcu (output rf_data_keying_line, input reference_clock_output);
endinterface : rfk_link_if

// *** rfk_mcu_end.sv ***
/*
 * Controller end: drives the keying line from a user data bit, forces it
 * low on a power-down request and samples the returned reference clock.
 * Assumes the link interface and a 40 MHz clock.
 */
`timescale 1ns/10ps
module rfk_mcu_end (
    input  wire logic   MCLK,
    input  wire logic   RST,
    input  wire logic   CE,
    input  wire logic   KEY_DATA,
    input  wire logic   PWRDN_REQ,
    output logic        PWRDN_OK,
    output logic        REF_SEEN,
    rfk_link_if.mcu     link
);
    logic key;
    logic ref_s1;
    logic ref_s2;
    wire  next_key = KEY_DATA & ~PWRDN_REQ;

    assign link.rf_data_keying_line = key;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            key      <= 1'b0;
            ref_s1   <= 1'b0;
            ref_s2   <= 1'b0;
            PWRDN_OK <= 1'b0;
            REF_SEEN <= 1'b0;
        end else if (CE) begin
            key      <= next_key;
            ref_s1   <= link.reference_clock_output;
            ref_s2   <= ref_s1;
            PWRDN_OK <= PWRDN_REQ & ~key;
            REF_SEEN <= ref_s2;
        end
    end
endmodule : rfk_mcu_end

// *** rfk_pkg.sv ***
/*
 * Package for the RF keying and standby control pair: timing constants,
 * PLL factor and transmitter states.
 * Assumes a single 40 MHz clock shared by both ends.
 */
package rfk_pkg;
    localparam int CLK_MHZ          = 40;
    localparam int WAKE_US          = 500;
    localparam int WAKE_CYC         = WAKE_US * CLK_MHZ;
    localparam int IDLE_MS          = 400;
    localparam int IDLE_CYC         = IDLE_MS * 1000 * CLK_MHZ;
    localparam int REF_DIV_CYC      = 8;
    localparam int PLL_MULT         = 32;
    localparam logic [7:0] PLL_MULT_VAL = 8'h20;
    localparam int CNT_W            = 25;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_WAKE    = 3'b010,
        ST_ACTIVE  = 3'b100
    } rfk_state_t;
endpackage : rfk_pkg

// *** rfk_props.sv ***
/* Checker for the keying link and transmitter status outputs.
   Assumes it is instantiated beside the link interface. */
`timescale 1ns/10ps
module rfk_props (
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       rf_data_keying_line,
    input wire logic       reference_clock_output,
    input wire logic       RF_ON,
    input wire logic       PLL_ON,
    input wire logic       STANDBY,
    input wire logic [7:0] PLL_MULT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    int wake;
    int hold;
    // Cycles since leaving standby, and cycles the keyed clock stood still
    always_ff @(posedge MCLK) begin
        wake <= (RST || STANDBY) ? 0 : wake + 1;
        hold <= (RF_ON && reference_clock_output == $past(reference_clock_output)) ? hold + 1 : 0;
    end
    a_key_gives_rf: assert property (RF_ON |-> $past(rf_data_keying_line, 3))
        else $error("carrier without key");
    a_fall_stops_rf: assert property ($fell(rf_data_keying_line) |-> ##[1:5] !RF_ON)
        else $error("carrier after key low");
    a_standby_quiet: assert property (STANDBY |-> !RF_ON && !PLL_ON && !reference_clock_output)
        else $error("active in standby");
    a_pll_factor: assert property (PLL_MULT == 8'h20)
        else $error("pll factor wrong");
    a_wake_starts: assert property ($rose(rf_data_keying_line) && STANDBY |-> ##[1:5] !STANDBY)
        else $error("no wake on edge");
    a_wake_blank: assert property (!STANDBY && wake < 19990 |-> !RF_ON)
        else $error("carrier too early");
    a_wake_ends: assert property (wake == 20010 && $past(rf_data_keying_line, 4) |-> RF_ON)
        else $error("carrier too late");
    a_ref_runs: assert property (hold < 10)
        else $error("ref clock stuck");
    cover property ($rose(RF_ON));
    cover property ($fell(RF_ON));
    cover property ($fell(STANDBY));
endmodule : rfk_props

// *** rfk_tx_end.sv ***
/*
 * Transmitter end: keying, wake-up delay, inactivity standby, gated
 * reference clock and fixed PLL factor.
 * Assumes the keying line arrives through the link interface.
 */
`timescale 1ns/10ps
module rfk_tx_end (
    input  wire logic   MCLK,
    input  wire logic   RST,
    input  wire logic   CE,
    output logic        RF_ON,
    output logic        PLL_ON,
    output logic        STANDBY,
    output logic [7:0]  PLL_MULT,
    rfk_link_if.tx      link
);
    // Synchroniser depth plus the edge-detect stage
    localparam int SYNC_N = 3;

    rfk_pkg::rfk_state_t       state;
    rfk_pkg::rfk_state_t       next_state;
    logic [SYNC_N-1:0]         sync;
    logic [rfk_pkg::CNT_W-1:0] idle_cnt;
    logic [rfk_pkg::CNT_W-1:0] next_idle_cnt;
    logic [rfk_pkg::CNT_W-1:0] wake_cnt;
    logic [rfk_pkg::CNT_W-1:0] next_wake_cnt;
    logic [3:0]                div_cnt;
    logic [3:0]                next_div_cnt;
    logic                      ref_clk;
    logic                      next_ref_clk;

    // Keying line prepended to the chain feeds the first stage
    wire [SYNC_N:0] sync_chain = {sync, link.rf_data_keying_line};
    wire            key_lvl    = sync[1];
    wire            key_prev   = sync[2];
    wire            edge_seen  = key_lvl ^ key_prev;
    wire            rise_seen  = key_lvl & ~key_prev;

    wire in_standby = state == rfk_pkg::ST_STANDBY;
    wire in_wake    = state == rfk_pkg::ST_WAKE;
    wire in_active  = state == rfk_pkg::ST_ACTIVE;

    wire idle_done = idle_cnt == rfk_pkg::CNT_W'(rfk_pkg::IDLE_CYC - 1);
    wire wake_done = wake_cnt == rfk_pkg::CNT_W'(rfk_pkg::WAKE_CYC - 1);
    wire div_wrap  = div_cnt == 4'(rfk_pkg::REF_DIV_CYC - 1);

    // Leaving active needs a full idle span with no edge
    wire go_standby = in_active & idle_done & ~edge_seen;
    wire go_active  = in_wake & wake_done;
    wire go_wake    = in_standby & rise_seen;

    // Carrier keyed from the next state so it drops together with standby
    wire next_rf      = (next_state == rfk_pkg::ST_ACTIVE) & key_lvl;
    wire next_pll_on  = next_state != rfk_pkg::ST_STANDBY;
    wire next_standby = next_state == rfk_pkg::ST_STANDBY;

    always_comb begin
        next_state = state;
        case (state)
            rfk_pkg::ST_STANDBY: begin
                if (go_wake) begin
                    next_state = rfk_pkg::ST_WAKE;
                end
            end
            rfk_pkg::ST_WAKE: begin
                if (go_active) begin
                    next_state = rfk_pkg::ST_ACTIVE;
                end
            end
            rfk_pkg::ST_ACTIVE: begin
                if (go_standby) begin
                    next_state = rfk_pkg::ST_STANDBY;
                end
            end
            default: begin
                next_state = rfk_pkg::ST_STANDBY;
            end
        endcase
    end

    // Any edge, or any state but active, restarts the idle count
    assign next_idle_cnt = (edge_seen || !in_active) ? '0 :
                           idle_done ? idle_cnt : idle_cnt + rfk_pkg::CNT_W'(1);
    assign next_wake_cnt = in_wake ? wake_cnt + rfk_pkg::CNT_W'(1) : '0;
    assign next_div_cnt  = (next_rf && !div_wrap) ? div_cnt + 4'(1) : '0;
    // Reference clock held low whenever the carrier is off
    assign next_ref_clk  = !next_rf ? 1'b0 :
                           div_wrap ? ~ref_clk : ref_clk;

    assign link.reference_clock_output = ref_clk;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge MCLK) begin
                if (RST) begin
                    sync[gi] <= 1'b0;
                end else if (CE) begin
                    sync[gi] <= sync_chain[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state <= rfk_pkg::ST_STANDBY;
        end else if (CE) begin
            state <= next_state;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            idle_cnt <= '0;
        end else if (CE) begin
            idle_cnt <= next_idle_cnt;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            wake_cnt <= '0;
        end else if (CE) begin
            wake_cnt <= next_wake_cnt;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            div_cnt <= '0;
        end else if (CE) begin
            div_cnt <= next_div_cnt;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ref_clk <= 1'b0;
        end else if (CE) begin
            ref_clk <= next_ref_clk;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            RF_ON <= 1'b0;
        end else if (CE) begin
            RF_ON <= next_rf;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            PLL_ON <= 1'b0;
        end else if (CE) begin
            PLL_ON <= next_pll_on;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            STANDBY <= 1'b1;
        end else if (CE) begin
            STANDBY <= next_standby;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            PLL_MULT <= rfk_pkg::PLL_MULT_VAL;
        end else if (CE) begin
            PLL_MULT <= rfk_pkg::PLL_MULT_VAL;
        end
    end
endmodule : rfk_tx_end

// *** tb_rf_keying_standby_control.sv ***
/* Testbench for the controller and transmitter ends joined by the link.
   Assumes the design package, interface and both ends are compiled first. */
`timescale 1ns/10ps
module tb_rf_keying_standby_control;
    logic       MCLK = 0, RST = 1, KEY_DATA = 0, PWRDN_REQ = 0, seen;
    logic       PWRDN_OK, REF_SEEN, RF_ON, PLL_ON, STANDBY;
    logic [7:0] PLL_MULT;
    int         fail_count = 0, num_checks = 0;
    rfk_link_if link ();
    rfk_mcu_end rfk_mcu_end_inst (.MCLK, .RST, .CE(1'b1), .KEY_DATA, .PWRDN_REQ, .PWRDN_OK,
        .REF_SEEN, .link(link));
    rfk_tx_end rfk_tx_end_inst (.MCLK, .RST, .CE(1'b1), .RF_ON, .PLL_ON, .STANDBY, .PLL_MULT,
        .link(link));
    rfk_props rfk_props_inst (.MCLK, .RST, .RF_ON, .PLL_ON, .STANDBY, .PLL_MULT,
        .rf_data_keying_line(link.rf_data_keying_line),
        .reference_clock_output(link.reference_clock_output));
    initial forever #12.5 MCLK = ~MCLK;
    task cyc(input int n);
        repeat (n) @(posedge MCLK);
        @(negedge MCLK);
    endtask : cyc
    task drv(input logic k, input logic p);
        @(posedge MCLK);
        KEY_DATA <= k;
        PWRDN_REQ <= p;
    endtask : drv
    task chk(input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: exp %0h got %0h", $time, exp, got);
        end
    endtask : chk
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        cyc(30000);
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge MCLK);
        RST <= 0;
        cyc(2);
        chk(1, STANDBY);
        chk(8'h20, PLL_MULT);
        chk(0, link.reference_clock_output);
        chk(0, PLL_ON);
        chk(0, link.rf_data_keying_line);
        chk(0, REF_SEEN);
        chk(0, PWRDN_OK);
        $display("test reset done");
        drv(1, 0);
        cyc(10);
        chk(0, RF_ON);
        chk(0, STANDBY);
        chk(1, PLL_ON);
        cyc(20000);
        chk(1, RF_ON);
        seen = 0;
        repeat (20) begin
            cyc(1);
            seen = seen | REF_SEEN;
        end
        chk(1, seen);
        $display("test wake done");
        drv(0, 0);
        cyc(8);
        chk(0, RF_ON);
        chk(0, link.reference_clock_output);
        drv(1, 0);
        cyc(8);
        chk(1, RF_ON);
        drv(1, 1);
        cyc(8);
        chk(0, link.rf_data_keying_line);
        chk(1, PWRDN_OK);
        $display("test keying done");
        finish_test;
    end
endmodule : tb_rf_keying_standby_control
